// ===== hdl/tws_slave.sv
// two-wire slave front end, page buffer and 256-byte memory
// assumes scl and sda arrive asynchronous; sda wired-and outside
// Summary of operation
// - pointer holds last access address plus one
// - pointer wraps from top to bottom
// - read address ack then send pointed byte
// - master ack keeps next byte coming
// - master nack ends read; release data line
// - data fall with clock high starts
// - data rise with clock high stops
// - data changes only while clock low
// - bytes plus ninth acknowledge bit
// - ack drives data low through clock high
// - first byte: type, select, direction, msb first
// - respond only when select bits match pins
// - direction one reads, zero writes
// - ack address only after full match
// - repeated start begins new transfer
// - write protect blocks memory and wiper changes
// - wipers are memory bytes at two addresses
// - pot zero has 100 positions
// - pot one spans full byte
// - pot zero codes above range give top
// - write sends word address then data, acked
// - page up to eight, committed at stop
// - busy write cycle ignores bus, no ack
// - address mismatch gives no ack, idle

`include "tws_cfg.svh"

// page buffer: plain synchronous fifo with flush
module tws_fifo
    import tws_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    // refuse depths the pointer wrap cannot serve
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
            $error("tws_fifo depth must be a power of two");
        end
    endgenerate

    logic [WIDTH-1:0] store [DEPTH]; // entry storage
    logic [AW:0] wr_ptr; // extra bit tells full from empty
    logic [AW:0] rd_ptr;
    wire do_push;
    wire do_pop;
    wire full_w;
    wire empty_w;

    // honest flags from pointer compare
    assign full_w = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty_w = (wr_ptr == rd_ptr);
    assign in_ready_out = ~full_w;
    assign out_valid_out = ~empty_w;
    assign do_push = in_valid_in & ~full_w;
    assign do_pop = out_ready_in & ~empty_w;
    assign out_data_out = store[rd_ptr[AW-1:0]];

    // pointers; flush drops everything held
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (flush_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // storage needs no reset
    always_ff @(posedge core_clk_in) begin
        if (do_push) begin
            store[wr_ptr[AW-1:0]] <= in_data_in;
        end
    end
endmodule

// top: slave protocol engine with memory and wiper outputs
module tws_slave
    import tws_pkg::*;
#(
    parameter int WRITE_CYCLES = `TWS_WRITE_TIME_US * `TWS_CLK_MHZ,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic write_protect_pin_in,
    input wire logic device_select_pin_msb_in,
    input wire logic device_select_pin_mid_in,
    input wire logic device_select_pin_lsb_in,
    output logic [7:0] pot_one_wiper_out,
    output logic [6:0] pot_zero_wiper_out,
    output logic busy_out
);
    // refuse timer lengths the counter cannot hold, and buffers smaller than a page
    generate
        if (WRITE_CYCLES < 1 || WRITE_CYCLES > 16777215) begin : g_bad
            $error("tws_slave write time out of range");
        end
        if (FIFO_DEPTH < 8) begin : g_small
            $error("tws_slave buffer must hold a page");
        end
    endgenerate

    // pin synchronisers, two flops each
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] wp_sync;
    logic [2:0] sel_sync1;
    logic [2:0] sel_sync2;
    logic scl_d; // previous synced clock
    logic sda_d; // previous synced data

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            wp_sync <= 2'h3; // open pin reads as protected
            sel_sync1 <= 3'h0;
            sel_sync2 <= 3'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            wp_sync <= {wp_sync[0], write_protect_pin_in};
            sel_sync1 <= {device_select_pin_msb_in, device_select_pin_mid_in, device_select_pin_lsb_in};
            sel_sync2 <= sel_sync1;
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end

    // bus events from synced lines
    wire scl_now = scl_sync[1];
    wire sda_now = sda_sync[1];
    wire scl_rise = scl_now & ~scl_d;
    wire scl_fall = ~scl_now & scl_d;
    wire start_ev = scl_now & scl_d & sda_d & ~sda_now;
    wire stop_ev = scl_now & scl_d & ~sda_d & sda_now;
    wire protect = wp_sync[1];

    // protocol state
    tws_state_t state;
    logic [3:0] bit_cnt; // bits seen in current byte
    logic [7:0] shreg; // received byte
    logic [7:0] tx_byte; // byte being sent
    logic in_ack; // ninth bit in progress (receive)
    logic master_ack; // sampled master ack (read)
    logic read_dir; // direction of this transfer
    logic [7:0] ptr; // word address pointer
    logic [3:0] page_cnt; // bytes taken in this page
    logic oe_q; // pull data low when set
    logic committing; // draining buffer into memory
    logic [23:0] wtimer; // internally timed write
    logic [7:0] mem [256]; // byte memory incl. wipers

    // timed write or drain makes the part deaf
    wire busy = committing | (wtimer != 24'h0);

    // received-byte decode, evaluated at the ninth fall
    wire byte_done = scl_fall & (bit_cnt == `TWS_BYTE_BITS) & ~in_ack;
    wire ack_end = scl_fall & in_ack;
    wire addr_match = (shreg[7:4] == `TWS_DEV_TYPE) && (shreg[3:1] == sel_sync2);
    wire rx_state = (state == TWS_ADDR) | (state == TWS_WORD) | (state == TWS_WDATA);

    // buffer handshake
    tws_wr_t push_entry;
    tws_wr_t pop_entry;
    wire buf_in_ready;
    wire buf_out_valid;
    wire page_room = (page_cnt < `TWS_PAGE_BYTES);
    wire push_req = byte_done & (state == TWS_WDATA) & ~protect & page_room;
    wire buf_flush = start_ev & ~busy; // unfinished page dropped
    wire pop_take = committing & buf_out_valid;

    assign push_entry.addr = ptr;
    assign push_entry.data = shreg;

    tws_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_page_buf (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .flush_in(buf_flush),
        .in_valid_in(push_req),
        .in_ready_out(buf_in_ready),
        .in_data_in(push_entry),
        .out_valid_out(buf_out_valid),
        .out_ready_in(committing),
        .out_data_out(pop_entry)
    );

    // a byte refused by a full buffer is dropped, still acked and not counted
    wire push_ok = push_req & buf_in_ready;

    // commit control: stop with buffered data starts drain
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            committing <= 1'b0;
            wtimer <= 24'h0;
        end else if (committing) begin
            if (!buf_out_valid) begin
                committing <= 1'b0;
                wtimer <= 24'(WRITE_CYCLES);
            end
        end else if (wtimer != 24'h0) begin
            wtimer <= wtimer - 24'h1;
        end else if (stop_ev && buf_out_valid && !protect) begin
            committing <= 1'b1;
        end
    end

    // memory: wipers reset to top, rest to zero
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < 256; i++) begin
                mem[i] <= (i == `TWS_ADDR_POT_ONE || i == `TWS_ADDR_POT_ZERO) ? `TWS_WIPER_RESET : `TWS_MEM_RESET;
            end
        end else if (pop_take) begin
            mem[pop_entry.addr] <= pop_entry.data;
        end
    end

    // wiper outputs from their memory bytes, pot zero clipped to its top
    wire [7:0] pot0_raw = mem[`TWS_ADDR_POT_ZERO];
    wire [7:0] pot0_clip = (pot0_raw > `TWS_POT0_MAX) ? `TWS_POT0_MAX : pot0_raw;

    // wiper flops; codes never exceed the pot range
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pot_one_wiper_out <= `TWS_WIPER_RESET;
            pot_zero_wiper_out <= 7'(`TWS_POT0_MAX);
        end else begin
            pot_one_wiper_out <= mem[`TWS_ADDR_POT_ONE];
            pot_zero_wiper_out <= pot0_clip[6:0];
        end
    end

    // next-state values of the protocol engine
    tws_state_t next_state;
    logic [3:0] next_bit_cnt;
    logic [7:0] next_shreg;
    logic [7:0] next_tx;
    logic [7:0] next_ptr;
    logic [3:0] next_page_cnt;
    logic next_in_ack;
    logic next_mack;
    logic next_dir;
    logic next_oe;

    // protocol sequencing on sampled scl edges
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_tx = tx_byte;
        next_ptr = ptr;
        next_page_cnt = page_cnt;
        next_in_ack = in_ack;
        next_mack = master_ack;
        next_dir = read_dir;
        next_oe = oe_q;
        if (start_ev) begin
            // repeated start also lands here
            next_state = busy ? TWS_IDLE : TWS_ADDR;
            next_bit_cnt = 4'h0;
            next_in_ack = 1'b0;
            next_page_cnt = 4'h0;
            next_oe = 1'b0;
        end else if (stop_ev) begin
            next_state = TWS_IDLE;
            next_oe = 1'b0;
        end else if (rx_state) begin
            if (scl_rise && bit_cnt < `TWS_BYTE_BITS && !in_ack) begin
                // sample while clock high, msb first
                next_shreg = {shreg[6:0], sda_now};
                next_bit_cnt = bit_cnt + 4'h1;
            end else if (byte_done) begin
                // ninth bit: decide acknowledge
                next_in_ack = 1'b1;
                next_oe = 1'b1;
                unique case (state)
                    TWS_ADDR: begin
                        if (addr_match) begin
                            next_dir = shreg[0];
                        end else begin
                            next_state = TWS_IDLE;
                            next_oe = 1'b0;
                            next_in_ack = 1'b0;
                        end
                    end
                    TWS_WORD: begin
                        next_ptr = shreg;
                    end
                    TWS_WDATA: begin
                        next_ptr = ptr + 8'h1;
                        if (push_ok) begin
                            next_page_cnt = page_cnt + 4'h1;
                        end
                    end
                    default: begin
                        next_state = TWS_IDLE;
                    end
                endcase
            end else if (ack_end) begin
                // release after ack low was held through high
                next_in_ack = 1'b0;
                next_bit_cnt = 4'h0;
                next_oe = 1'b0;
                if (state == TWS_ADDR && read_dir) begin
                    next_state = TWS_RDATA;
                    next_tx = {mem[ptr][6:0], 1'b0};
                    next_oe = ~mem[ptr][7];
                    next_ptr = ptr + 8'h1;
                    next_bit_cnt = 4'h1;
                end else if (state == TWS_ADDR) begin
                    next_state = TWS_WORD;
                end else begin
                    next_state = TWS_WDATA;
                end
            end
        end else if (state == TWS_RDATA) begin
            if (scl_fall && bit_cnt < `TWS_BYTE_BITS) begin
                // change data only after clock falls
                next_oe = ~tx_byte[7];
                next_tx = {tx_byte[6:0], 1'b0};
                next_bit_cnt = bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `TWS_BYTE_BITS) begin
                next_oe = 1'b0; // master owns the ninth bit
                next_bit_cnt = `TWS_MACK_BIT;
            end else if (scl_rise && bit_cnt == `TWS_MACK_BIT) begin
                next_mack = ~sda_now;
            end else if (scl_fall && bit_cnt == `TWS_MACK_BIT) begin
                if (master_ack) begin
                    // next incremented byte
                    next_tx = {mem[ptr][6:0], 1'b0};
                    next_oe = ~mem[ptr][7];
                    next_ptr = ptr + 8'h1;
                    next_bit_cnt = 4'h1;
                end else begin
                    // leave line high for the stop
                    next_state = TWS_IDLE;
                    next_oe = 1'b0;
                end
            end
        end
    end

    // protocol registers; pointer survives between transfers
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= TWS_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            tx_byte <= 8'h00;
            ptr <= 8'h00;
            page_cnt <= 4'h0;
            in_ack <= 1'b0;
            master_ack <= 1'b0;
            read_dir <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            tx_byte <= next_tx;
            ptr <= next_ptr;
            page_cnt <= next_page_cnt;
            in_ack <= next_in_ack;
            master_ack <= next_mack;
            read_dir <= next_dir;
            oe_q <= next_oe;
        end
    end

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe_out = oe_q;
    assign busy_out = busy;
endmodule

// ===== hdl/tws_cfg.svh
// constants for the two-wire slave with potentiometer memory
// assumes inclusion by bare name from the top and the bench
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH
// core clock rate in MHz (40 ns period)
`define TWS_CLK_MHZ 25
// internally timed write, in microseconds (plain default)
`define TWS_WRITE_TIME_US 10000
// device-type code, arbitrary neutral value
`define TWS_DEV_TYPE 4'h5
// wiper locations in the byte memory
`define TWS_ADDR_POT_ONE 8'hF8
`define TWS_ADDR_POT_ZERO 8'hF9
// reset contents
`define TWS_MEM_RESET 8'h00
`define TWS_WIPER_RESET 8'hFF
// pot zero range limit
`define TWS_POT0_MAX 8'h63
// page write length in bytes
`define TWS_PAGE_BYTES 4'h8
// bits per byte on the wire
`define TWS_BYTE_BITS 4'h8
`define TWS_MACK_BIT 4'h9
`endif

// ===== hdl/tws_pkg.sv
// types shared by the two-wire slave and its page buffer
// assumes tws_cfg.svh holds all numeric constants
package tws_pkg;
    // protocol states, one-hot
    typedef enum logic [6:0] {
        TWS_IDLE = 7'b0000001,
        TWS_ADDR = 7'b0000010,
        TWS_WORD = 7'b0000100,
        TWS_WDATA = 7'b0001000,
        TWS_RDATA = 7'b0010000,
        TWS_HOLD = 7'b0100000,
        TWS_SPARE = 7'b1000000
    } tws_state_t;
    // one buffered page-write entry
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } tws_wr_t;
endpackage

// ===== dv/tws_slave_properties.sv
// checker for the two-wire slave, top-level ports only
// assumes one core clock domain and the async active-low reset
module tws_slave_properties #(
    parameter int WRITE_CYCLES = 400,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic write_protect_pin_in,
    input wire logic device_select_pin_msb_in,
    input wire logic device_select_pin_mid_in,
    input wire logic device_select_pin_lsb_in,
    input wire logic [7:0] pot_one_wiper_out,
    input wire logic [6:0] pot_zero_wiper_out,
    input wire logic busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // worst busy: full buffer drain plus the timed write
    localparam int BUSY_MAX = WRITE_CYCLES + FIFO_DEPTH + 8;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    // busy lasts a short stretch at least
    sequence s_busy_run;
        busy_out [*8];
    endsequence
    // and ends in bounded time
    sequence s_busy_end;
        ##[1:BUSY_MAX] !busy_out;
    endsequence
    property p_oe_moves_low;
        $changed(sda_oe_out) |-> !scl_in;
    endproperty
    a_oe_moves_low: assert property (p_oe_moves_low) else $error("drive moved with clock high");
    property p_ack_held_high;
        (sda_oe_out && $rose(scl_in)) |-> sda_oe_out [*4];
    endproperty
    a_ack_held_high: assert property (p_ack_held_high) else $error("low drop in clock high");
    property p_pot0_cap;
        pot_zero_wiper_out <= 7'h63;
    endproperty
    a_pot0_cap: assert property (p_pot0_cap) else $error("pot zero past top");
    property p_no_ack_busy;
        busy_out |-> !sda_oe_out;
    endproperty
    a_no_ack_busy: assert property (p_no_ack_busy) else $error("drive while busy");
    property p_wp_freeze;
        write_protect_pin_in [*4] |-> $stable(pot_one_wiper_out) && $stable(pot_zero_wiper_out);
    endproperty
    a_wp_freeze: assert property (p_wp_freeze) else $error("wiper moved under protect");
    // wipers follow memory, which changes only in a commit
    property p_wiper_commit;
        ($changed(pot_one_wiper_out) || $changed(pot_zero_wiper_out)) |-> busy_out || $past(busy_out);
    endproperty
    a_wiper_commit: assert property (p_wiper_commit) else $error("wiper moved outside commit");
    property p_busy_min;
        $rose(busy_out) |-> s_busy_run;
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    property p_busy_bounded;
        $rose(busy_out) |-> s_busy_end;
    endproperty
    a_busy_bounded: assert property (p_busy_bounded) else $error("busy never ends");
endmodule

bind tws_slave tws_slave_properties #(.WRITE_CYCLES(WRITE_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) i_props (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .write_protect_pin_in(write_protect_pin_in),
    .device_select_pin_msb_in(device_select_pin_msb_in), .device_select_pin_mid_in(device_select_pin_mid_in),
    .device_select_pin_lsb_in(device_select_pin_lsb_in), .pot_one_wiper_out(pot_one_wiper_out),
    .pot_zero_wiper_out(pot_zero_wiper_out), .busy_out(busy_out));

// ===== dv/tws_master_model.sv
// behavioural two-wire bus master driving clock and data
// assumes a pull-up on the data wire; clock rests high between frames
module tws_master_model (
    input wire logic core_clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus: both lines released high
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // set both lines on an edge, then hold n clocks
    task automatic put(input logic c, input logic d, input int n);
        @(posedge core_clk_in);
        scl_out <= c;
        sda_low_out <= !d;
        repeat (n - 1) @(posedge core_clk_in);
    endtask
    // one bit of 320 ns: data moves only in clock low, sampled late in high
    // four core clocks low leaves one clock of margin over the slave's sync lag
    task automatic bitx(input logic b, output logic r);
        put(1'b0, !sda_low_out, 2);
        put(1'b0, b, 2);
        put(1'b1, b, 4);
        r = sda_in;
    endtask
    // start, also used as repeated start
    task automatic start();
        put(1'b0, !sda_low_out, 2);
        put(1'b0, 1'b1, 2);
        put(1'b1, 1'b1, 4);
        put(1'b1, 1'b0, 4);
    endtask
    // stop leaves the bus idle
    task automatic stop();
        put(1'b0, !sda_low_out, 2);
        put(1'b0, 1'b0, 2);
        put(1'b1, 1'b0, 4);
        put(1'b1, 1'b1, 4);
    endtask
    // byte out msb first, ninth clock reads the ack
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    // byte in; released ninth bit is a nack that ends the read
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(!more, r);
    endtask
endmodule

// ===== dv/tws_slave_tb_top.sv
// self-checking bench for the two-wire slave
// assumes the master model and a pull-up on the data wire
`include "tws_cfg.svh"
module tws_slave_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WCYC = 400; // short timed write, polling still sees it
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wp = 1'b1; // open pin reads as protected
    logic [2:0] pins = 3'b101; // strap of this device
    logic scl, sda_low, sda_oe, sda_o, busy;
    logic [7:0] pot1;
    logic [6:0] pot0;
    wire logic sda = !(sda_low || (sda_oe && !sda_o)); // wired-and with pull-up
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    logic [7:0] wdat [0:15];
    logic [7:0] exp_q [$];
    always #20 clk = !clk;
    tws_slave #(.WRITE_CYCLES(WCYC), .FIFO_DEPTH(16)) i_dut (
        .core_clk_in(clk), .rstn_in(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
        .sda_oe_out(sda_oe), .write_protect_pin_in(wp), .device_select_pin_msb_in(pins[2]),
        .device_select_pin_mid_in(pins[1]), .device_select_pin_lsb_in(pins[0]),
        .pot_one_wiper_out(pot1), .pot_zero_wiper_out(pot0), .busy_out(busy));
    tws_master_model i_mst (.core_clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
    // verdict and end of run
    task automatic wrap_up();
        if (error_cnt == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // byte compare, acks widened to a byte
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] adr(input logic [2:0] s, input logic rw);
        return {`TWS_DEV_TYPE, s, rw};
    endfunction
    // send a byte and check the answer bit
    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic a;
        i_mst.wbyte(b, a);
        chk({7'h00, a}, {7'h00, exp_ack});
    endtask
    // wait for commit to finish, bounded
    task automatic idle_wait();
        int n;
        n = 0;
        repeat (8) @(posedge clk);
        while (busy && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk({7'h00, busy}, 8'h00);
    endtask
    // write transfer of n data bytes, every byte acked
    task automatic write(input logic [7:0] word, input int n);
        i_mst.start();
        send(adr(pins, 1'b0), 1'b1);
        send(word, 1'b1);
        for (int i = 0; i < n; i++) send(wdat[i], 1'b1);
        i_mst.stop();
    endtask
    // read n bytes, last one left unacked, against the queue
    task automatic read(input int n);
        logic [7:0] d;
        i_mst.start();
        send(adr(pins, 1'b1), 1'b1);
        for (int i = 0; i < n; i++) begin
            i_mst.rbyte(i < n - 1, d);
            chk(d, exp_q.pop_front());
        end
        i_mst.stop();
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        chk(pot1, 8'hFF);
        chk({1'b0, pot0}, 8'h63);
        // only the strapped select code is answered
        for (int s = 0; s < 8; s++) begin
            i_mst.start();
            send(adr(s[2:0], 1'b0), s[2:0] == pins);
            i_mst.stop();
        end
        i_mst.start();
        send({~`TWS_DEV_TYPE, pins, 1'b1}, 1'b0);
        i_mst.stop();
        wp <= 1'b0;
        wdat[0] = 8'hC3;
        write(8'h01, 1);
        idle_wait();
        // page over both wipers, ninth byte dropped
        for (int i = 0; i < 16; i++) wdat[i] = 8'hA1 + 8'(i);
        wdat[2] = 8'h5A;
        wdat[3] = 8'h64;
        wdat[8] = 8'hEE;
        write(8'hF6, 9);
        i_mst.start();
        send(adr(pins, 1'b0), 1'b0);
        i_mst.stop();
        idle_wait();
        chk(pot1, 8'h5A);
        chk({1'b0, pot0}, 8'h63);
        // random read running through the top and wrapping
        exp_q = '{8'hA1, 8'hA2, 8'h5A, 8'h64, 8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'h00, 8'h00, 8'h00};
        i_mst.start();
        send(adr(pins, 1'b0), 1'b1);
        send(8'hF6, 1'b1);
        read(11);
        exp_q = '{8'hC3};
        read(1);
        // protected write acked but dropped
        wp <= 1'b1;
        wdat[0] = 8'h11;
        write(8'hF8, 1);
        idle_wait();
        chk(pot1, 8'h5A);
        exp_q = '{8'h5A};
        i_mst.start();
        send(adr(pins, 1'b0), 1'b1);
        send(8'hF8, 1'b1);
        read(1);
        wrap_up();
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            wrap_up();
        end
    end
endmodule
